/* File: hw/cir_regs.sv */
/*
 * card information register set: operating conditions, identity and
 * access parameters, reachable only through dedicated commands.
 * assumes a command front end that decodes bus commands into cmd_code,
 * factory fuses for the identity and a capacity strap, all synchronous.
 */
`timescale 1ns/1ps
module cir_regs
    import cir_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // factory identity fuses and capacity strap
    input wire logic [REG_W-1:CID_FUSE_LO] identity_fuse,
    input wire logic [CID_DATE_HI:CID_DATE_LO] date_fuse,
    input wire logic capacity_strap,
    // command from the card bus front end
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_code,
    input wire logic [REG_W-1:0] cmd_data,
    // response to the front end
    output logic rsp_valid,
    output logic rsp_err,
    output logic [REG_W-1:0] rsp_data,
    // power-up status
    output logic card_ready
);

    typedef struct packed {
        cir_state_t st;
        logic [PWRUP_CNT_W-1:0] cnt;
        logic capacity_status;
        logic temporary_protect;
        logic [6:0] csd_crc;
        logic rsp_valid;
        logic rsp_err;
        logic [REG_W-1:0] rsp_data;
    } cir_regs_t;

    cir_regs_t s_q;
    cir_regs_t s_d;

    logic [OTP_N-1:0] otp_val;
    logic [OTP_N-1:0] otp_lock;
    logic [OTP_N-1:0] otp_clash;
    logic otp_en;
    logic [OCR_W-1:0] operating_conditions;
    logic [REG_W-1:0] card_identity;
    logic [REG_W-1:0] card_access_parameters;
    logic [REG_W-1:0] prog_fixed_diff;
    logic [6:0] id_crc;
    logic prog_ok;

    // operating-conditions word; unlisted bits stay zero
    always_comb
    begin
        operating_conditions = '0;
        operating_conditions[OCR_VWIN_HI:OCR_VWIN_LO] = OCR_VWIN_ALL;
        operating_conditions[OCR_LV_SWITCH] = 1'b0;
        operating_conditions[OCR_READY_BIT] =
            (s_q.st == CIR_ST_READY);
        operating_conditions[OCR_CAP_BIT] = s_q.capacity_status;
    end

    // identity: fused fields, zero nibble, date, computed crc, end bit
    cir_crc7 u_id_crc
    (
        .msg({identity_fuse, 4'h0, date_fuse}), // from fuses: no comb loop
        .crc(id_crc)
    );

    always_comb
    begin
        card_identity = '0;
        card_identity[REG_W-1:CID_FUSE_LO] = identity_fuse;
        card_identity[CID_RSV_HI:CID_RSV_LO] = 4'h0;
        card_identity[CID_DATE_HI:CID_DATE_LO] = date_fuse;
        card_identity[CRC_HI:CRC_LO] = id_crc;
        card_identity[END_BIT] = 1'b1;
    end

    // access parameters: reserved bits default to zero
    always_comb
    begin
        card_access_parameters = '0;
        card_access_parameters[CSD_LAYOUT_HI:CSD_LAYOUT_LO] =
            CSD_LAYOUT_V10;
        card_access_parameters[CSD_ASYNC_ACCESS_TIME_HI:CSD_ASYNC_ACCESS_TIME_LO] = ASYNC_ACCESS_TIME_VAL;
        card_access_parameters[CSD_CLOCKED_ACCESS_TIME_HI:CSD_CLOCKED_ACCESS_TIME_LO] = CLOCKED_ACCESS_TIME_VAL;
        card_access_parameters[CSD_RATE_HI:CSD_RATE_LO] = RATE_VAL;
        card_access_parameters[CSD_CCC_HI:CSD_CCC_LO] = CCC_VAL;
        card_access_parameters[CSD_RBL_HI:CSD_RBL_LO] = RBL_VAL;
        card_access_parameters[CSD_WBL_HI:CSD_WBL_LO] = WBL_VAL;
        card_access_parameters[CSD_RPART] = RPART_VAL[0];
        card_access_parameters[CSD_WMIS] = WMIS_VAL[0];
        card_access_parameters[CSD_RMIS] = RMIS_VAL[0];
        card_access_parameters[CSD_DSR] = DSR_VAL[0];
        card_access_parameters[CSD_WPART] = WPART_VAL[0];
        card_access_parameters[CSD_SIZE_HI:CSD_SIZE_LO] = SIZE_VAL;
        card_access_parameters[CSD_CURR_HI:CSD_CURR_LO] = CURR_VAL;
        card_access_parameters[CSD_MULT_HI:CSD_MULT_LO] = MULT_VAL;
        card_access_parameters[CSD_ERBLK] = ERBLK_VAL[0];
        card_access_parameters[CSD_SECT_HI:CSD_SECT_LO] = SECT_VAL;
        card_access_parameters[CSD_WPG_HI:CSD_WPG_LO] = WPG_VAL;
        card_access_parameters[CSD_WPG_EN] = WPG_EN_VAL[0];
        card_access_parameters[CSD_R2W_HI:CSD_R2W_LO] = R2W_VAL;
        card_access_parameters[CSD_TMP_PROT] = s_q.temporary_protect;
        card_access_parameters[CRC_HI:CRC_LO] = s_q.csd_crc;
        card_access_parameters[END_BIT] = 1'b1;
        for (int i = 0; i < OTP_N; i++)
        begin
            card_access_parameters[OTP_POS[i]] = otp_val[i];
        end
    end

    // write-once bits, one cell per bit
    genvar g;
    generate
        for (g = 0; g < OTP_N; g++)
        begin : g_otp
            cir_otp_bit u_otp
            (
                .clk(clk),
                .nrst(nrst),
                .prog_en(otp_en),
                .prog_val(cmd_data[OTP_POS[g]]),
                .bit_q(otp_val[g]),
                .locked(otp_lock[g])
            );
            // locked bit asked to take a different value
            assign otp_clash[g] =
                otp_lock[g] && (cmd_data[OTP_POS[g]] != otp_val[g]);
        end
    endgenerate

    // a program is taken only if every fixed bit matches the register
    assign prog_fixed_diff =
        (cmd_data ^ card_access_parameters) & ~CSD_PROG_MASK;
    assign prog_ok = (prog_fixed_diff == '0) && (otp_clash == '0);
    assign otp_en = cmd_valid && (cmd_code == CMD_PROG_CSD) &&
        (s_q.st == CIR_ST_READY) && prog_ok;

    // power-up sequencing and command handling
    always_comb
    begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.rsp_err = 1'b0;
        unique case (s_q.st)
            CIR_ST_PWRUP:
            begin
                // count out the power-up routine, then catch the strap
                if (s_q.cnt == PWRUP_CNT_W'(PWRUP_CYCLES - 1))
                begin
                    s_d.st = CIR_ST_READY;
                    s_d.capacity_status = capacity_strap;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            CIR_ST_READY:
            begin
                s_d.cnt = s_q.cnt;
            end
        endcase
        // dedicated commands are the only access path
        if (cmd_valid)
        begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = '0;
            if (cmd_code == CMD_READ_OCR)
            begin
                s_d.rsp_data[OCR_W-1:0] = operating_conditions;
            end
            else if (s_q.st != CIR_ST_READY)
            begin
                s_d.rsp_err = 1'b1; // busy: only the conditions word answers
            end
            else if (cmd_code == CMD_READ_CID)
            begin
                s_d.rsp_data = card_identity;
            end
            else if (cmd_code == CMD_READ_CSD)
            begin
                s_d.rsp_data = card_access_parameters;
            end
            else if (prog_ok)
            begin
                s_d.temporary_protect = cmd_data[CSD_TMP_PROT];
                s_d.csd_crc = cmd_data[CRC_HI:CRC_LO];
            end
            else
            begin
                s_d.rsp_err = 1'b1; // fixed bit changed or locked bit moved
            end
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_q <= '{st: CIR_ST_PWRUP, cnt: '0, capacity_status: 1'b0,
                temporary_protect: 1'b0, csd_crc: CSD_CRC_RST,
                rsp_valid: 1'b0, rsp_err: 1'b0, rsp_data: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_err = s_q.rsp_err;
    assign rsp_data = s_q.rsp_data;
    assign card_ready = (s_q.st == CIR_ST_READY);

endmodule // cir_regs

/* File: hw/cir_pkg.sv */
/*
 * shared constants of the card information register set: command codes,
 * operating-conditions bit layout, identity and access-parameter field
 * positions, factory field values and power-up timing.
 * assumes a 10 MHz core clock; nothing else is needed from outside.
 */
package cir_pkg;

    // clock and power-up routine timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PWRUP_TIME_NS = 1000;
    localparam int unsigned PWRUP_CYCLES =
        (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PWRUP_CNT_W = 8;

    // dedicated commands of the card bus front end
    localparam logic [1:0] CMD_READ_OCR = 2'h0;
    localparam logic [1:0] CMD_READ_CID = 2'h1;
    localparam logic [1:0] CMD_READ_CSD = 2'h2;
    localparam logic [1:0] CMD_PROG_CSD = 2'h3;

    // register widths
    localparam int unsigned OCR_W = 32;
    localparam int unsigned REG_W = 128;

    // operating-conditions layout
    localparam int unsigned OCR_VWIN_LO = 15;
    localparam int unsigned OCR_VWIN_HI = 23;
    localparam logic [8:0] OCR_VWIN_ALL = 9'h1FF;
    localparam int unsigned OCR_LV_SWITCH = 24;
    localparam int unsigned OCR_CAP_BIT = 30;
    localparam int unsigned OCR_READY_BIT = 31;

    // identity layout: bits above the reserved nibble come from fuses
    localparam int unsigned CID_FUSE_LO = 24;
    localparam int unsigned CID_RSV_HI = 23;
    localparam int unsigned CID_RSV_LO = 20;
    localparam int unsigned CID_DATE_HI = 19;
    localparam int unsigned CID_DATE_LO = 8;
    localparam int unsigned CRC_HI = 7;
    localparam int unsigned CRC_LO = 1;
    localparam int unsigned END_BIT = 0;
    localparam int unsigned CRC_MSG_W = 120;

    // access-parameter field positions
    localparam int unsigned CSD_LAYOUT_HI = 127;
    localparam int unsigned CSD_LAYOUT_LO = 126;
    localparam int unsigned CSD_ASYNC_ACCESS_TIME_HI = 119;
    localparam int unsigned CSD_ASYNC_ACCESS_TIME_LO = 112;
    localparam int unsigned CSD_CLOCKED_ACCESS_TIME_HI = 111;
    localparam int unsigned CSD_CLOCKED_ACCESS_TIME_LO = 104;
    localparam int unsigned CSD_RATE_HI = 103;
    localparam int unsigned CSD_RATE_LO = 96;
    localparam int unsigned CSD_CCC_HI = 95;
    localparam int unsigned CSD_CCC_LO = 84;
    localparam int unsigned CSD_RBL_HI = 83;
    localparam int unsigned CSD_RBL_LO = 80;
    localparam int unsigned CSD_RPART = 79;
    localparam int unsigned CSD_WMIS = 78;
    localparam int unsigned CSD_RMIS = 77;
    localparam int unsigned CSD_DSR = 76;
    localparam int unsigned CSD_SIZE_HI = 73;
    localparam int unsigned CSD_SIZE_LO = 62;
    localparam int unsigned CSD_CURR_HI = 61;
    localparam int unsigned CSD_CURR_LO = 50;
    localparam int unsigned CSD_MULT_HI = 49;
    localparam int unsigned CSD_MULT_LO = 47;
    localparam int unsigned CSD_ERBLK = 46;
    localparam int unsigned CSD_SECT_HI = 45;
    localparam int unsigned CSD_SECT_LO = 39;
    localparam int unsigned CSD_WPG_HI = 38;
    localparam int unsigned CSD_WPG_LO = 32;
    localparam int unsigned CSD_WPG_EN = 31;
    localparam int unsigned CSD_R2W_HI = 28;
    localparam int unsigned CSD_R2W_LO = 26;
    localparam int unsigned CSD_WBL_HI = 25;
    localparam int unsigned CSD_WBL_LO = 22;
    localparam int unsigned CSD_WPART = 21;
    localparam int unsigned CSD_TMP_PROT = 12;

    // write-once bits: format group, copy, permanent protect, format
    localparam int unsigned OTP_N = 5;
    localparam int unsigned OTP_POS [OTP_N] = '{15, 14, 13, 11, 10};

    // bits a program command may change; all others must match
    localparam logic [127:0] CSD_PROG_MASK =
        128'h0000_0000_0000_0000_0000_0000_0000_FCFE;

    // factory values of read-only access-parameter fields
    localparam logic [1:0] CSD_LAYOUT_V10 = 2'h0;
    localparam logic [7:0] ASYNC_ACCESS_TIME_VAL = 8'h0E;
    localparam logic [7:0] CLOCKED_ACCESS_TIME_VAL = 8'h00;
    localparam logic [7:0] RATE_VAL = 8'h32;
    localparam logic [11:0] CCC_VAL = 12'h5B5;
    localparam logic [3:0] RBL_VAL = 4'h9;
    localparam logic [0:0] RPART_VAL = 1'h1;
    localparam logic [0:0] WMIS_VAL = 1'h0;
    localparam logic [0:0] RMIS_VAL = 1'h0;
    localparam logic [0:0] DSR_VAL = 1'h0;
    localparam logic [11:0] SIZE_VAL = 12'hFFF;
    localparam logic [11:0] CURR_VAL = 12'hFFF;
    localparam logic [2:0] MULT_VAL = 3'h7;
    localparam logic [0:0] ERBLK_VAL = 1'h1;
    localparam logic [6:0] SECT_VAL = 7'h7F;
    localparam logic [6:0] WPG_VAL = 7'h00;
    localparam logic [0:0] WPG_EN_VAL = 1'h0;
    localparam logic [2:0] R2W_VAL = 3'h4;
    localparam logic [3:0] WBL_VAL = 4'h9;
    localparam logic [0:0] WPART_VAL = 1'h0;

    // reset values of programmable fields
    localparam logic [6:0] CSD_CRC_RST = 7'h00;
    localparam logic [0:0] OTP_RST = 1'h0;

    // controller states
    typedef enum logic [1:0] {
        CIR_ST_PWRUP = 2'b01,
        CIR_ST_READY = 2'b10
    } cir_state_t;

endpackage

/* File: hw/cir_crc7.sv */
/*
 * combinational crc7 (x^7 + x^3 + 1) over a 120-bit message, msb first.
 * assumes the message is stable while the result is sampled.
 */
`timescale 1ns/1ps
module cir_crc7
    import cir_pkg::*;
(
    // message in
    input wire logic [CRC_MSG_W-1:0] msg,
    // check value out
    output logic [6:0] crc
);

    // shift each message bit through the polynomial
    always_comb
    begin
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        fb = 1'b0;
        for (int i = CRC_MSG_W - 1; i >= 0; i--)
        begin
            fb = msg[i] ^ c[6];
            c = {c[5:0], 1'b0};
            c[0] = fb;
            c[3] = c[3] ^ fb;
        end
        crc = c;
    end

endmodule // cir_crc7

/* File: hw/cir_otp_bit.sv */
/*
 * one write-once bit: takes the first accepted program value, then locks.
 * assumes the caller only raises prog_en for an accepted program command.
 */
`timescale 1ns/1ps
module cir_otp_bit
    import cir_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // program request
    input wire logic prog_en,
    input wire logic prog_val,
    // stored bit and lock
    output logic bit_q,
    output logic locked
);

    typedef struct packed {
        logic val;
        logic lock;
    } cir_otp_t;

    cir_otp_t s_q;
    cir_otp_t s_d;

    // first program stores and locks, later ones change nothing
    always_comb
    begin
        s_d = s_q;
        if (prog_en && !s_q.lock)
        begin
            s_d.val = prog_val;
            s_d.lock = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_q <= '{val: OTP_RST, lock: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bit_q = s_q.val;
    assign locked = s_q.lock;

endmodule // cir_otp_bit

/* File: sim/cir_host.sv */
/*
 * host controller model: issues one card bus command at a time.
 * assumes the bench calls xfer and that commands are decoded upstream.
 */
`timescale 1ns/1ps
module cir_host
    import cir_pkg::*;
(
    // clock
    input wire logic clk,
    // command out
    output logic cmd_valid,
    output logic [1:0] cmd_code,
    output logic [REG_W-1:0] cmd_data,
    // response in
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [REG_W-1:0] rsp_data
);
    // idle bus at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 2'h0;
        cmd_data = '0;
    end

    // raise, hold over the taking edge, park inverted, take the answer
    task automatic xfer(input logic [1:0] c, input logic [127:0] d,
        output logic v, output logic e, output logic [127:0] r);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~c;
        cmd_data <= ~d;
        @(negedge clk);
        v = rsp_valid;
        e = rsp_err;
        r = rsp_data;
    endtask

    // capacity flag only trusted once the ready bit is set
    function automatic logic cap_of(input logic [31:0] cond);
        return cond[OCR_READY_BIT] ? cond[OCR_CAP_BIT] : 1'b0;
    endfunction
endmodule // cir_host

/* File: sim/cir_regs_monitor.sv */
/*
 * port checker of the card information register set.
 * assumes the single clock and the synchronous low reset of the block.
 */
`timescale 1ns/1ps
module cir_regs_monitor
    import cir_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // watched inputs
    input wire logic [REG_W-1:CID_FUSE_LO] identity_fuse,
    input wire logic [CID_DATE_HI:CID_DATE_LO] date_fuse,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_code,
    // watched outputs
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [REG_W-1:0] rsp_data,
    input wire logic card_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [7:0] up_cnt_q;
    logic [7:0] up_cnt_d;

    // cycles since reset release, saturating
    always_comb
    begin
        up_cnt_d = (up_cnt_q == 8'hFF) ? up_cnt_q : up_cnt_q + 8'h01;
    end
    always_ff @(posedge clk)
    begin
        if (!nrst)
            up_cnt_q <= 8'h00;
        else
            up_cnt_q <= up_cnt_d;
    end

    a_volt_win: assert property (
        rsp_valid && $past(cmd_code) == CMD_READ_OCR
        |-> rsp_data[23:15] == 9'h1FF) else $error("voltage bits wrong");
    a_low_rsvd: assert property (
        rsp_valid && $past(cmd_code) == CMD_READ_OCR
        |-> rsp_data[14:0] == 15'h0) else $error("low status bits set");
    a_lv_switch: assert property (
        rsp_valid && $past(cmd_code) == CMD_READ_OCR
        |-> rsp_data[29:24] == 6'h0) else $error("switch bits set");
    a_ready_time: assert property (
        card_ready == (up_cnt_q >= PWRUP_CYCLES))
        else $error("ready at wrong time");
    a_resp_once: assert property (
        cmd_valid |=> rsp_valid ##1 !rsp_valid
        || $past(cmd_valid, 1) == 1'b0) else $error("no response");
    a_err_notready: assert property (
        $past(cmd_code) != CMD_READ_OCR && !$past(card_ready) && rsp_valid
        |-> rsp_err && rsp_data == 0) else $error("early command taken");
    a_id_layout: assert property (
        rsp_valid && !rsp_err && $past(cmd_code) == CMD_READ_CID
        |-> rsp_data[127:24] == identity_fuse && rsp_data[23:20] == 4'h0
        && rsp_data[19:8] == date_fuse && rsp_data[0])
        else $error("identity wrong");
    a_param_end: assert property (
        rsp_valid && !rsp_err && $past(cmd_code) == CMD_READ_CSD
        |-> rsp_data[0]) else $error("end bit low");
    a_param_rsvd: assert property (
        rsp_valid && $past(cmd_code) == CMD_READ_CSD
        |-> {rsp_data[125:120], rsp_data[75:74], rsp_data[30:29],
        rsp_data[20:16]} == 15'h0) else $error("reserved set");
endmodule // cir_regs_monitor

bind cir_regs cir_regs_monitor mon_u (.clk(clk), .nrst(nrst),
    .identity_fuse(identity_fuse), .date_fuse(date_fuse),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_data(rsp_data), .card_ready(card_ready));

/* File: sim/testbench.sv */
/*
 * self-checking bench of the card information register set.
 * assumes cir_host as the far side and the bound port checker.
 */
`timescale 1ns/1ps
module testbench;
    import cir_pkg::*;
    // design ports
    logic clk;
    logic nrst;
    logic [REG_W-1:CID_FUSE_LO] identity_fuse;
    logic [CID_DATE_HI:CID_DATE_LO] date_fuse;
    logic capacity_strap;
    logic cmd_valid;
    logic [1:0] cmd_code;
    logic [REG_W-1:0] cmd_data;
    logic rsp_valid;
    logic rsp_err;
    logic [REG_W-1:0] rsp_data;
    logic card_ready;
    // bench state
    int error_cnt = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h5B1AB2A3;
    logic [127:0] csd_mod;
    logic [10:0] flip_err = 11'b01111111100;
    logic [127:0] flip [11] = '{128'h7000, 128'h1000, 128'h4000, 128'h8000,
        128'h0400, 128'h1 << 100, 128'h1, 128'h100, 128'h1 << 125,
        128'h1 << 126, 128'h1000};

    cir_regs dut_u (.clk(clk), .nrst(nrst), .identity_fuse(identity_fuse),
        .date_fuse(date_fuse), .capacity_strap(capacity_strap),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
        .card_ready(card_ready));
    cir_host host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_data(rsp_data));

    // expectations
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [6:0] crc7(input logic [119:0] m);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int k = 119; k >= 0; k--)
        begin
            fb = m[k] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction
    function automatic logic [127:0] cid_exp();
        logic [119:0] m;
        m = {identity_fuse, 4'h0, date_fuse};
        return {m, crc7(m), 1'b1};
    endfunction
    function automatic logic [127:0] ocr_exp(input logic rdy, input logic cap);
        return {96'h0, rdy, rdy & cap, 6'h00, OCR_VWIN_ALL, 15'h0000};
    endfunction
    function automatic logic [127:0] csd_def();
        return {CSD_LAYOUT_V10, 6'h00, ASYNC_ACCESS_TIME_VAL, CLOCKED_ACCESS_TIME_VAL, RATE_VAL, CCC_VAL,
            RBL_VAL, RPART_VAL, WMIS_VAL, RMIS_VAL, DSR_VAL, 2'h0, SIZE_VAL,
            CURR_VAL, MULT_VAL, ERBLK_VAL, SECT_VAL, WPG_VAL, WPG_EN_VAL,
            2'h0, R2W_VAL, WBL_VAL, WPART_VAL, 5'h00, 8'h00, CSD_CRC_RST,
            1'b1};
    endfunction

    // comparison and closing
    task automatic check(input string nm, input logic [127:0] s,
        input logic [127:0] x);
        n_tests++;
        if (s !== x)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one command with its full expected answer
    task automatic cmd(input logic [1:0] c, input logic [127:0] d,
        input logic ee, input logic [127:0] ed);
        logic v;
        logic e;
        logic [127:0] r;
        host_u.xfer(c, d, v, e, r);
        check("rsp_valid", {127'h0, v}, 128'h1);
        check("rsp_err", {127'h0, e}, {127'h0, ee});
        check("rsp_data", r, ed);
    endtask
    task automatic prog(input logic [127:0] f, input logic ee);
        cmd(CMD_PROG_CSD, csd_mod ^ f, ee, 128'h0);
        if (!ee)
            csd_mod = csd_mod ^ f;
        cmd(CMD_READ_CSD, 128'h0, 1'b0, csd_mod);
    endtask
    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        seed = lfsr(seed);
        capacity_strap <= seed[3];
        identity_fuse <= {seed, lfsr(seed), ~seed, seed[7:0]};
        date_fuse <= seed[31:20];
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        csd_mod = csd_def();
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (card_ready !== 1'b1 && n < 30)
        begin
            @(negedge clk);
            n++;
        end
        check("card_ready", {127'h0, card_ready}, 128'h1);
    endtask

    // clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // watchdog
    initial
    begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    // main sequence
    initial
    begin
        logic v;
        logic e;
        logic [127:0] r;
        nrst = 1'b0;
        identity_fuse = '0;
        date_fuse = '0;
        capacity_strap = 1'b0;
        do_reset();
        host_u.xfer(CMD_READ_OCR, 128'h0, v, e, r);
        check("ocr_busy", r & ~(128'h1 << 30), ocr_exp(0, 0));
        cmd(CMD_READ_CID, 128'h0, 1'b1, 128'h0);
        cmd(CMD_PROG_CSD, csd_mod, 1'b1, 128'h0);
        wait_ready();
        cmd(CMD_READ_OCR, 128'h0, 1'b0, ocr_exp(1, capacity_strap));
        host_u.xfer(CMD_READ_OCR, 128'h0, v, e, r);
        check("cap", {127'h0, host_u.cap_of(r[31:0])},
            {127'h0, capacity_strap});
        cmd(CMD_READ_CID, 128'h0, 1'b0, cid_exp());
        cmd(CMD_READ_CSD, 128'h0, 1'b0, csd_mod);
        $display("test power-up and reads done");
        for (int k = 0; k < 11; k++)
            prog(flip[k], flip_err[k]);
        $display("test program table done");
        for (int k = 0; k < 16; k++)
        begin
            seed = lfsr(seed);
            prog({96'h0, seed} & 128'h10FE, 1'b0);
        end
        cmd(CMD_READ_CID, 128'h0, 1'b0, cid_exp());
        $display("test random rewrites done");
        do_reset();
        @(negedge clk);
        check("ready_low", {127'h0, card_ready}, 128'h0);
        wait_ready();
        prog(128'h8000, 1'b0);
        $display("test second reset done");
        complete_run();
    end
endmodule // testbench
